// ---- design/ctmw_pkg.sv ----
// Package with modes, chip states and timing constants for the transceiver mode block.
`default_nettype none
package ctmw_pkg;
  typedef enum logic [1:0] {
    CTMW_MODE_OFF = 2'b00,
    CTMW_MODE_WAKE = 2'b01,
    CTMW_MODE_RXONLY = 2'b10,
    CTMW_MODE_NORMAL = 2'b11
  } ctmw_mode_type;
  typedef enum logic [2:0] {
    CTMW_CHIP_INIT = 3'b000,
    CTMW_CHIP_NORMAL = 3'b001,
    CTMW_CHIP_STOP = 3'b010,
    CTMW_CHIP_SLEEP = 3'b011,
    CTMW_CHIP_RESTART = 3'b100,
    CTMW_CHIP_FAILSAFE = 3'b101
  } ctmw_chip_type;
  typedef enum logic [2:0] {
    CTMW_WK_IDLE = 3'b000,
    CTMW_WK_DOM1 = 3'b001,
    CTMW_WK_REC = 3'b010,
    CTMW_WK_DOM2 = 3'b011,
    CTMW_WK_WAIT = 3'b100
  } ctmw_wake_type;
  localparam int CTMW_CLK_HZ = 10_000_000;
  localparam int CTMW_EN_TIME_NS = 20_000;
  localparam int CTMW_WAKE_MIN_NS = 500;
  localparam int CTMW_WAKE_MAX_NS = 1_800_000;
  localparam int CTMW_TXTO_NS = 2_000_000;
  localparam int CTMW_EN_CYC = (CTMW_EN_TIME_NS * (CTMW_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CTMW_WAKE_MIN_CYC = (CTMW_WAKE_MIN_NS * (CTMW_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CTMW_WAKE_MAX_CYC = CTMW_WAKE_MAX_NS * (CTMW_CLK_HZ / 1_000_000) / 1000;
  localparam int CTMW_TXTO_CYC = CTMW_TXTO_NS * (CTMW_CLK_HZ / 1_000_000) / 1000;
  localparam int CTMW_CNT_W = 20;
  localparam logic [1:0] CTMW_MODE_RESET = 2'h0;
endpackage
`default_nettype wire

// ---- design/ctmw_wake_if.sv ----
// Interface carrying bus level, arming and result between mode control and wake detector.
`default_nettype none
interface ctmw_wake_if;
  logic arm;
  logic bus_dom;
  logic wake;
  modport ctrl (output arm, output bus_dom, input wake);
  modport det (input arm, input bus_dom, output wake);
endinterface
`default_nettype wire

// ---- design/ctmw_wake_detect.sv ----
// Wake pattern detector: dominant, recessive, dominant phases within time window.
`default_nettype none
module ctmw_wake_detect
  import ctmw_pkg::*;
#(
  parameter int MIN_CYC = CTMW_WAKE_MIN_CYC,
  parameter int MAX_CYC = CTMW_WAKE_MAX_CYC
)
(
  input wire logic clk_in, // core clock
  input wire logic rst_in, // async reset, high
  ctmw_wake_if.det wif // bus level and result
);
  ctmw_wake_type state;
  logic [CTMW_CNT_W-1:0] cnt;
  logic ok_len;
  logic too_long;
  assign ok_len = cnt >= CTMW_CNT_W'(MIN_CYC);
  assign too_long = cnt >= CTMW_CNT_W'(MAX_CYC);

  // Phase length counter restarts on every bus level change and saturates at the limit.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt <= '0;
    else if (state == CTMW_WK_IDLE || state == CTMW_WK_WAIT)
      cnt <= '0;
    else if ((state == CTMW_WK_REC) == wif.bus_dom)
      cnt <= '0;
    else if (!too_long)
      cnt <= cnt + 1'b1;
  end

  // A phase counts only if it ended after the filter time and before the limit.
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= CTMW_WK_IDLE;
    else if (!wif.arm)
      state <= CTMW_WK_IDLE;
    else
    begin
      case (state)
        CTMW_WK_IDLE:
          if (wif.bus_dom)
            state <= CTMW_WK_DOM1;
        CTMW_WK_DOM1, CTMW_WK_REC, CTMW_WK_DOM2:
          // An over-long phase is judged when it ends, so its tail cannot pass as a new phase.
          if ((state == CTMW_WK_REC) == wif.bus_dom)
          begin
            if (!ok_len || too_long)
              state <= wif.bus_dom ? CTMW_WK_DOM1 : CTMW_WK_IDLE;
            else if (state == CTMW_WK_DOM1)
              state <= CTMW_WK_REC;
            else if (state == CTMW_WK_REC)
              state <= CTMW_WK_DOM2;
            else
              state <= CTMW_WK_WAIT;
          end
        CTMW_WK_WAIT:
          state <= CTMW_WK_WAIT;
        default:
          state <= CTMW_WK_IDLE;
      endcase
    end
  end
  assign wif.wake = (state == CTMW_WK_WAIT);

  AST_WAKE_NEEDS_ARM: assert property (@(posedge clk_in) disable iff (rst_in)
    !wif.arm |=> state == CTMW_WK_IDLE)
    else $error("Wake detector left idle while disarmed.");
  AST_WAKE_AFTER_DOM2: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(wif.wake) |-> $past(state) == CTMW_WK_DOM2)
    else $error("Wake raised without a second dominant phase.");
endmodule
`default_nettype wire

// ---- design/ctmw_top.sv ----
// Transceiver mode control, transmit gating, enable delay, timeout and wake signalling.
// Overview of operation
// - Reset into off, bus high impedance.
// - Off mode ignores wake activity.
// - Off selectable in every chip state except fail-safe.
// - Normal entered only in chip normal; kept in stop.
// - Normal mode driver follows transmit input.
// - Dominant pending at delay end is suppressed.
// - Receive output follows differential receiver in normal and receive-only.
// - Receive-only disables driver, still receives.
// - Receive-only entered only in normal/stop.
// - Wake mode selectable in stop/sleep/restart/normal.
// - Fail-safe forces wake-capable mode.
// - Wake pulls receive low until mode change.
// - Wake needs dom-rec-dom phases within window.
// - Mode chosen by written mode field.
// - Mode reads wake-capable; rearm by toggle/stop/fail-safe.
// - Dominant timeout turns driver off, mode stays normal, flags.
// - Wake in sleep requests restart state.
`default_nettype none
module ctmw_top
  import ctmw_pkg::*;
#(
  parameter int EN_CYC = CTMW_EN_CYC,
  parameter int WAKE_MIN_CYC = CTMW_WAKE_MIN_CYC,
  parameter int WAKE_MAX_CYC = CTMW_WAKE_MAX_CYC,
  parameter int TXTO_CYC = CTMW_TXTO_CYC
)
(
  input wire logic core_clk_in, // 10 MHz core clock
  input wire logic rst_in, // async reset, high
  input wire ctmw_pkg::ctmw_chip_type chip_state_in, // chip operating state
  input wire logic [1:0] mode_wr_data_in, // requested mode field
  input wire logic mode_wr_in, // one-cycle write strobe
  input wire logic tx_bit_input_in, // transmit input, low dominant
  input wire logic bus_dom_in, // differential receiver, high dominant
  output logic [1:0] mode_out, // current mode field
  output logic drv_en_out, // bus driver drives dominant
  output logic bias_en_out, // bus biased, not high impedance
  output logic rx_out, // receive output
  output logic fault_out, // sticky dominant timeout flag
  output logic restart_req_out // pulse: wake in sleep
);
  ctmw_wake_if wif();
  ctmw_mode_type mode;
  logic [CTMW_CNT_W-1:0] en_cnt;
  logic [CTMW_CNT_W-1:0] to_cnt;
  logic enabled;
  logic tx_armed;
  logic timed_out;
  logic woken;
  logic wake_spent;
  logic rearm_block;
  ctmw_chip_type chip_prev;
  logic norm_ok;
  logic wake_ok;

  assign norm_ok = chip_state_in == CTMW_CHIP_NORMAL || chip_state_in == CTMW_CHIP_STOP;
  assign wake_ok = norm_ok || chip_state_in == CTMW_CHIP_SLEEP ||
    chip_state_in == CTMW_CHIP_RESTART;

  ctmw_wake_detect #(
    .MIN_CYC(WAKE_MIN_CYC),
    .MAX_CYC(WAKE_MAX_CYC)
  ) u_wake (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .wif(wif.det)
  );
  assign wif.bus_dom = bus_dom_in;
  assign wif.arm = (mode == CTMW_MODE_WAKE) && !wake_spent && !rearm_block;

  // Mode field: writes are checked against chip state; fail-safe forces wake.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      mode <= ctmw_mode_type'(CTMW_MODE_RESET);
    else if (chip_state_in == CTMW_CHIP_FAILSAFE)
      mode <= CTMW_MODE_WAKE;
    else if (mode_wr_in)
    begin
      case (mode_wr_data_in)
        CTMW_MODE_OFF:
          mode <= CTMW_MODE_OFF;
        CTMW_MODE_WAKE:
          if (wake_ok)
            mode <= CTMW_MODE_WAKE;
        CTMW_MODE_RXONLY:
          if (norm_ok)
            mode <= CTMW_MODE_RXONLY;
        CTMW_MODE_NORMAL:
          if (chip_state_in == CTMW_CHIP_NORMAL)
            mode <= CTMW_MODE_NORMAL;
        default:
          mode <= mode;
      endcase
    end
    else if (!norm_ok && (mode == CTMW_MODE_NORMAL || mode == CTMW_MODE_RXONLY))
      mode <= CTMW_MODE_WAKE;
  end

  // Wake latch; mode stays wake-capable and only a mode change clears it.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      woken <= 1'b0;
    else if (mode != CTMW_MODE_WAKE)
      woken <= 1'b0;
    else if (wif.wake)
      woken <= 1'b1;
  end

  // Detector lockout after a wake. It is kept apart from the receive latch so that a
  // stop or fail-safe entry rearms detection while the receive output stays low.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      wake_spent <= 1'b0;
    else if (wif.wake && mode == CTMW_MODE_WAKE)
      wake_spent <= 1'b1;
    else if (mode != CTMW_MODE_WAKE || rearm_block)
      wake_spent <= 1'b0;
  end

  // Rearm: a stop or fail-safe entry clears the detector, which then restarts.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      chip_prev <= CTMW_CHIP_INIT;
      rearm_block <= 1'b0;
    end
    else
    begin
      chip_prev <= chip_state_in;
      rearm_block <= chip_state_in != chip_prev && (chip_state_in == CTMW_CHIP_STOP ||
        chip_state_in == CTMW_CHIP_FAILSAFE);
    end
  end

  // Enable delay after entering normal, then wait for a recessive transmit input.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      en_cnt <= '0;
      enabled <= 1'b0;
      tx_armed <= 1'b0;
    end
    else if (mode != CTMW_MODE_NORMAL)
    begin
      en_cnt <= '0;
      enabled <= 1'b0;
      tx_armed <= 1'b0;
    end
    else
    begin
      if (!enabled)
      begin
        en_cnt <= en_cnt + 1'b1;
        enabled <= en_cnt >= CTMW_CNT_W'(EN_CYC - 1);
      end
      if (enabled && tx_bit_input_in)
        tx_armed <= 1'b1;
    end
  end

  // Dominant timeout: driver off until input released; flag is sticky.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      to_cnt <= '0;
      timed_out <= 1'b0;
    end
    else if (mode != CTMW_MODE_NORMAL || tx_bit_input_in)
    begin
      to_cnt <= '0;
      timed_out <= 1'b0;
    end
    else if (to_cnt >= CTMW_CNT_W'(TXTO_CYC))
      timed_out <= 1'b1;
    else
      to_cnt <= to_cnt + 1'b1;
  end

  // Registered outputs.
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_out <= CTMW_MODE_RESET;
      drv_en_out <= 1'b0;
      bias_en_out <= 1'b0;
      rx_out <= 1'b1;
      fault_out <= 1'b0;
      restart_req_out <= 1'b0;
    end
    else
    begin
      mode_out <= mode;
      drv_en_out <= mode == CTMW_MODE_NORMAL && tx_armed && !timed_out &&
        !tx_bit_input_in;
      bias_en_out <= mode == CTMW_MODE_NORMAL || mode == CTMW_MODE_RXONLY;
      if (mode == CTMW_MODE_NORMAL || mode == CTMW_MODE_RXONLY)
        rx_out <= !bus_dom_in;
      else
        rx_out <= !(mode == CTMW_MODE_WAKE && woken);
      if (timed_out)
        fault_out <= 1'b1;
      restart_req_out <= wif.wake && !wake_spent && chip_state_in == CTMW_CHIP_SLEEP;
    end
  end

  sequence s_dom_held;
    mode == CTMW_MODE_NORMAL && !tx_bit_input_in;
  endsequence
  AST_OFF_AFTER_RESET: assert property (@(posedge core_clk_in)
    $fell(rst_in) |-> mode_out == 2'h0 && !bias_en_out && !drv_en_out)
    else $error("Not off after reset.");
  AST_OFF_NO_WAKE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mode == CTMW_MODE_OFF && $past(mode) == CTMW_MODE_OFF |=> rx_out)
    else $error("Receive output low in off mode.");
  AST_OFF_ANY_STATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mode_wr_in && mode_wr_data_in == 2'h0 && chip_state_in != CTMW_CHIP_FAILSAFE
    |=> mode == CTMW_MODE_OFF)
    else $error("Off write not taken.");
  AST_NORMAL_STATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(mode == CTMW_MODE_NORMAL) |-> $past(chip_state_in) == CTMW_CHIP_NORMAL)
    else $error("Normal entered outside chip normal.");
  AST_DRV_FOLLOWS: assert property (@(posedge core_clk_in) disable iff (rst_in)
    drv_en_out |-> $past(!tx_bit_input_in))
    else $error("Driver dominant with recessive input.");
  AST_NO_EARLY_DOM: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !tx_armed |=> !drv_en_out)
    else $error("Dominant sent before recessive seen.");
  AST_RXONLY_NODRV: assert property (@(posedge core_clk_in) disable iff (rst_in)
    mode == CTMW_MODE_RXONLY |=> !drv_en_out && rx_out == $past(!bus_dom_in))
    else $error("Receive-only mode misbehaves.");
  AST_FAILSAFE_WAKE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    chip_state_in == CTMW_CHIP_FAILSAFE |=> mode == CTMW_MODE_WAKE)
    else $error("Fail-safe did not force wake mode.");
  AST_WAKE_RX_LOW: assert property (@(posedge core_clk_in) disable iff (rst_in)
    wif.wake && mode == CTMW_MODE_WAKE ##1 mode == CTMW_MODE_WAKE |=> !rx_out)
    else $error("Wake not shown on receive output.");
  AST_TIMEOUT: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_dom_held [*3] ##0 timed_out |=> !drv_en_out && fault_out)
    else $error("Timeout did not stop driver.");
endmodule
`default_nettype wire

// ---- tb/ctmw_host_model.sv ----
// Model of the protocol controller that drives the transmit input.
`default_nettype none
module ctmw_host_model
(
  input wire logic clk_in, // core clock
  output logic tx_out // transmit input, low dominant
);
  timeunit 1ns;
  timeprecision 1ns;
  initial tx_out = 1'b1;
  // A real controller stays recessive here; early is only for the suppression test.
  task automatic enable_wait(input int cyc, input logic early);
    tx_out = !early;
    repeat (cyc) @(negedge clk_in);
  endtask
  task automatic put(input logic v, input int cyc);
    tx_out = v;
    repeat (cyc) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// ---- tb/ctmw_testbench.sv ----
// Self-checking bench for the transceiver mode and wake block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ctmw_pkg::*;
  localparam int EN = 20;
  localparam int WMIN = 5;
  localparam int WMAX = 50;
  localparam int TO = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ctmw_chip_type chip = CTMW_CHIP_INIT;
  logic [1:0] wdat = 2'h0;
  logic wr = 1'b0;
  logic bus_ext = 1'b0;
  logic tx;
  logic [1:0] mode;
  logic drv;
  logic bias;
  logic rx;
  logic fault;
  logic rreq;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_cyc = 0;
  int n_restart = 0;
  always #50 clk = ~clk;
  // The bus is wired back so that our own dominant bits reach the receiver.
  ctmw_top #(.EN_CYC(EN), .WAKE_MIN_CYC(WMIN), .WAKE_MAX_CYC(WMAX), .TXTO_CYC(TO)) i_dut (
    .core_clk_in(clk), .rst_in(rst), .chip_state_in(chip), .mode_wr_data_in(wdat),
    .mode_wr_in(wr), .tx_bit_input_in(tx), .bus_dom_in(bus_ext | drv), .mode_out(mode),
    .drv_en_out(drv), .bias_en_out(bias), .rx_out(rx), .fault_out(fault),
    .restart_req_out(rreq));
  ctmw_host_model i_host (.clk_in(clk), .tx_out(tx));
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    n_cyc <= n_cyc + 1;
    if (rreq === 1'b1)
      n_restart <= n_restart + 1;
    if (n_cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic chkm(input logic [1:0] exp);
    tests_run++;
    if (mode !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t mode %b want %b", $time, mode, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrm(input logic [1:0] m);
    wdat = m;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(3);
  endtask
  task automatic pat(input int d1, input int r, input int d2);
    bus_ext = 1'b1;
    tick(d1);
    bus_ext = 1'b0;
    tick(r);
    bus_ext = 1'b1;
    tick(d2);
    bus_ext = 1'b0;
    tick(5);
  endtask
  task automatic t_reset();
    chkm(2'h0);
    chk(bias | drv | fault, 1'b0, "reset outputs");
    chk(rx, 1'b1, "reset rx");
    pat(10, 10, 10);
    chk(rx, 1'b1, "wake seen in off");
  endtask
  task automatic t_table();
    ctmw_chip_type st[5];
    logic [3:0] ok[5];
    st = '{CTMW_CHIP_INIT, CTMW_CHIP_NORMAL, CTMW_CHIP_STOP, CTMW_CHIP_SLEEP, CTMW_CHIP_RESTART};
    ok = '{4'h1, 4'hf, 4'h7, 4'h3, 4'h3};
    for (int s = 0; s < 5; s++)
      for (int m = 0; m < 4; m++)
      begin
        chip = st[s];
        tick(2);
        wrm(2'h0);
        wrm(m[1:0]);
        chkm(ok[s][m] ? m[1:0] : 2'h0);
      end
    chip = CTMW_CHIP_FAILSAFE;
    tick(3);
    chkm(2'h1);
    chip = CTMW_CHIP_NORMAL;
    tick(2);
  endtask
  task automatic t_tx();
    wrm(2'h0);
    wrm(2'h3);
    chk(bias, 1'b1, "bus not biased in normal");
    i_host.enable_wait(EN + 5, 1'b1);
    chk(drv, 1'b0, "early dominant sent");
    i_host.put(1'b1, 3);
    i_host.put(1'b0, 3);
    chk(drv, 1'b1, "dominant not driven");
    chk(rx, 1'b0, "rx not dominant");
    i_host.put(1'b1, 3);
    chk(drv, 1'b0, "recessive driven");
    chk(rx, 1'b1, "rx not recessive");
    wrm(2'h2);
    i_host.put(1'b0, 5);
    chk(drv, 1'b0, "driver on in rx-only");
    bus_ext = 1'b1;
    tick(3);
    chk(rx, 1'b0, "rx-only not receiving");
    bus_ext = 1'b0;
    i_host.put(1'b1, 3);
    wrm(2'h3);
    i_host.enable_wait(EN + 2, 1'b0);
    i_host.put(1'b0, TO + 10);
    chk(drv | !fault, 1'b0, "timeout missed");
    chkm(2'h3);
    i_host.put(1'b1, 3);
    i_host.put(1'b0, 3);
    chk(drv, 1'b1, "no resume after timeout");
    i_host.put(1'b1, 3);
  endtask
  task automatic t_wake();
    chip = CTMW_CHIP_SLEEP;
    tick(3);
    chkm(2'h1);
    chip = CTMW_CHIP_NORMAL;
    tick(2);
    wrm(2'h1);
    pat(3, 10, 10);
    tick(WMAX + 5);
    pat(10, WMAX + 10, 10);
    tick(WMAX + 5);
    chk(rx, 1'b1, "false wake");
    pat(10, 10, 10);
    tick(20);
    chk(rx, 1'b0, "wake missed");
    chkm(2'h1);
    wrm(2'h0);
    chk(bias, 1'b0, "bus biased in off");
    chk(rx, 1'b1, "rx held after mode change");
    wrm(2'h1);
    chip = CTMW_CHIP_SLEEP;
    tick(3);
    pat(10, 10, 10);
    chk(rx, 1'b0, "no wake after rearm");
    chk(n_restart == 1, 1'b1, "restart request");
    chip = CTMW_CHIP_STOP;
    tick(3);
    chk(rx, 1'b0, "rx released without mode change");
    chip = CTMW_CHIP_SLEEP;
    tick(3);
    pat(10, 10, 10);
    chk(n_restart == 2, 1'b1, "no wake after stop rearm");
    chip = CTMW_CHIP_NORMAL;
    wrm(2'h3);
    chkm(2'h3);
    chk(rx, 1'b1, "rx not following bus after wake");
  endtask
  initial
  begin
    tick(12);
    rst = 1'b0;
    tick(1);
    t_reset();
    t_table();
    t_tx();
    t_wake();
    results();
  end
endmodule
`default_nettype wire
